// ===== core/fdl_fault_locator.sv
// Fault distance locator: trigger, blocking, loop selection, serial
// division for reactance, per-unit current and distance, twelve-entry log.
// Assumes all inputs come from logic on core_clk_i and that the
// measurement magnitudes are refreshed by the front end every 5 ms.
//
// Function
// - Trigger is any selectable internal binary signal
// - Blocked trigger skips the fault calculation
// - Phase-earth voltage availability picks allowed loops
// - Without voltages, single-phase faults not recorded
// - Single phase over threshold records phase-neutral loop
// - Two phases give pair; three give AB; the code records L123 for three
// - No current condition met, no record
// - Threshold in tenths of nominal, default one
// - Line_a setting, default 0.125
// - Three currents, four voltages, 5 ms refresh
// - Blocking sampled at each program cycle start
// - Blocked pick-up raises blocked, nothing more
// - Masked ON/OFF events for trigger and calculation
// - Resettable cumulative trigger counter
// - Circular log of twelve latest records
// - Record holds stamp, event, type, direction, values
// - Settings change live without stopping
`timescale 1ns/10ps
module fdl_fault_locator #(
    parameter int unsigned NSIG = 32,
    parameter int unsigned SEL_W = 5,
    parameter int unsigned NBLK = 8,
    parameter int unsigned MS_CYC = fdl_pkg::MS_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cycle_tick_i,
    input wire logic [NSIG-1:0] bin_sig_i,
    input wire logic [SEL_W-1:0] trig_sel_i,
    input wire logic [NBLK-1:0] blk_src_i,
    input wire logic [NBLK-1:0] blk_sel_i,
    input wire logic pe_wired_i,
    input wire logic [15:0] phase_a_current_i,
    input wire logic [15:0] phase_b_current_i,
    input wire logic [15:0] phase_c_current_i,
    input wire logic [15:0] volt_1_i,
    input wire logic [15:0] volt_2_i,
    input wire logic [15:0] volt_3_i,
    input wire logic [15:0] volt_4_i,
    input wire logic [15:0] nom_current_i,
    input wire logic [8:0] trig_thr_i,
    input wire logic [15:0] line_a_i,
    input wire logic [2:0] set_group_i,
    input wire logic [1:0] dir_i,
    input wire logic evt_on_en_i,
    input wire logic evt_off_en_i,
    input wire logic cnt_clr_i,
    input wire logic [3:0] log_rd_idx_i,
    output logic triggered_o,
    output logic calc_o,
    output logic blocked_o,
    output logic [3:0] evt_o,
    output logic [31:0] evt_stamp_o,
    output logic [15:0] trig_cnt_o,
    output logic [3:0] log_count_o,
    output logic log_valid_o,
    output logic [31:0] log_stamp_o,
    output logic [3:0] log_event_o,
    output logic [2:0] log_type_o,
    output logic [1:0] log_dir_o,
    output logic [15:0] log_x_o,
    output logic [15:0] log_pu_o,
    output logic [15:0] log_prim_o,
    output logic [15:0] log_dist_o,
    output logic [2:0] log_grp_o
);
    import fdl_pkg::*;

    // ----------------------------------------------------------------
    // Reset release and time base
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    logic [31:0] ms_div_q;
    logic [31:0] stamp_q;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ms_div_q <= '0;
            stamp_q <= '0;
        end
        else if (ms_div_q == 32'(MS_CYC - 1))
        begin
            ms_div_q <= '0;
            stamp_q <= stamp_q + 32'h1;
        end
        else
            ms_div_q <= ms_div_q + 32'h1;
    end

    // ----------------------------------------------------------------
    // Program cycle sampling of trigger, blocking and settings
    // ----------------------------------------------------------------
    logic trig_now;
    logic blk_now;
    logic trig_prev_q;
    logic blk_q;
    logic [8:0] thr_q;
    logic [15:0] line_a_q;
    logic [2:0] grp_q;
    logic trig_rise;
    logic trig_fall;
    logic accept;
    logic busy;

    assign trig_now = bin_sig_i[trig_sel_i];
    assign blk_now = |(blk_src_i & blk_sel_i);
    assign trig_rise = cycle_tick_i && trig_now && !trig_prev_q;
    assign trig_fall = cycle_tick_i && !trig_now && trig_prev_q;
    // Blocking is taken from this same cycle's sample, before the trigger
    assign accept = trig_rise && !blk_now;

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_prev_q <= 1'b0;
            blk_q <= 1'b0;
            thr_q <= THR_RST;
            line_a_q <= LINE_A_RST;
            grp_q <= GROUP_RST;
        end
        else if (cycle_tick_i)
        begin
            blk_q <= blk_now;
            trig_prev_q <= trig_now;
            thr_q <= trig_thr_i;
            line_a_q <= line_a_i;
            grp_q <= set_group_i;
        end
    end

    // ----------------------------------------------------------------
    // Trigger state, blocked indication, counter
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            triggered_o <= 1'b0;
            blocked_o <= 1'b0;
            trig_cnt_o <= '0;
        end
        else
        begin
            if (accept)
                triggered_o <= 1'b1;
            else if (trig_fall)
                triggered_o <= 1'b0;
            // Held until the trigger falls; the blocked event is not processed
            if (trig_rise && blk_now)
                blocked_o <= 1'b1;
            else if (trig_fall)
                blocked_o <= 1'b0;
            // A clear together with a new trigger in the same cycle restarts the count at one
            if (accept)
                trig_cnt_o <= cnt_clr_i ? 16'h1 : trig_cnt_o + 16'h1;
            else if (cnt_clr_i)
                trig_cnt_o <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Loop selection from currents at the trigger instant
    // ----------------------------------------------------------------
    logic pe_ok;
    logic [2:0] over;
    logic [31:0] thr_amp;
    logic loop_ok;
    logic pp_loop;
    fdl_ftype_t loop_type;
    logic [15:0] ix;
    logic [15:0] iy;
    logic [15:0] ux;
    logic [15:0] uy;

    assign pe_ok = pe_wired_i &&
        ((volt_1_i | volt_2_i | volt_3_i | volt_4_i) != 16'h0);
    assign thr_amp = 32'(thr_q) * 32'(nom_current_i);
    always_comb
    begin
        over[0] = 32'(phase_a_current_i) * 32'(THR_SCALE) >= thr_amp;
        over[1] = 32'(phase_b_current_i) * 32'(THR_SCALE) >= thr_amp;
        over[2] = 32'(phase_c_current_i) * 32'(THR_SCALE) >= thr_amp;
    end

    always_comb
    begin
        loop_ok = 1'b1;
        pp_loop = 1'b1;
        loop_type = FT_L12;
        ix = phase_a_current_i;
        iy = phase_b_current_i;
        ux = volt_1_i;
        uy = volt_2_i;
        case (over)
            3'b111: loop_type = FT_L123;
            3'b011: loop_type = FT_L12;
            3'b110:
            begin
                loop_type = FT_L23;
                ix = phase_b_current_i;
                iy = phase_c_current_i;
                ux = volt_2_i;
                uy = volt_3_i;
            end
            3'b101:
            begin
                loop_type = FT_L31;
                ix = phase_c_current_i;
                iy = phase_a_current_i;
                ux = volt_3_i;
                uy = volt_1_i;
            end
            3'b001, 3'b010, 3'b100:
            begin
                pp_loop = 1'b0;
                loop_ok = pe_ok;
                loop_type = over[0] ? FT_L1N : (over[1] ? FT_L2N : FT_L3N);
                ix = over[0] ? phase_a_current_i :
                    (over[1] ? phase_b_current_i : phase_c_current_i);
                ux = over[0] ? volt_1_i : (over[1] ? volt_2_i : volt_3_i);
                iy = 16'h0;
                uy = 16'h0;
            end
            default: loop_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Calculation sequencer
    // ----------------------------------------------------------------
    fdl_state_t state_q;
    logic [31:0] op_num_q;
    logic [17:0] op_den_q;
    logic div_go_q;
    logic div_done_q;
    logic [31:0] div_quo_q;
    logic [15:0] quo_sat;
    logic [2:0] f_type_q;
    logic [1:0] f_dir_q;
    logic [15:0] f_x_q;
    logic [15:0] f_pu_q;
    logic [15:0] f_prim_q;
    logic [15:0] f_dist_q;
    logic [2:0] f_grp_q;
    logic [31:0] f_stamp_q;

    assign busy = (state_q != ST_IDLE);
    assign quo_sat = (div_quo_q[31:16] != 16'h0) ? 16'hffff : div_quo_q[15:0];

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            op_num_q <= '0;
            op_den_q <= '0;
            div_go_q <= 1'b0;
            f_type_q <= '0;
            f_dir_q <= DIR_NONE;
            f_x_q <= '0;
            f_pu_q <= '0;
            f_prim_q <= '0;
            f_dist_q <= '0;
            f_grp_q <= GROUP_RST;
            f_stamp_q <= '0;
        end
        else
        begin
            div_go_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                    // A trigger that arrives mid-calculation is counted only
                    if (accept && loop_ok)
                    begin
                        state_q <= ST_DIVX;
                        // Loop reactance in mohm from the 5 ms magnitudes
                        op_num_q <= (32'(ux) + 32'(uy)) * 32'(MOHM_PER_OHM);
                        op_den_q <= pp_loop ? 18'(ix) + 18'(iy) : 18'(ix);
                        div_go_q <= 1'b1;
                        f_type_q <= loop_type;
                        f_dir_q <= (dir_i == DIR_REV) ? DIR_REV :
                            ((dir_i == DIR_FWD) ? DIR_FWD : DIR_NONE);
                        f_prim_q <= ix;
                        f_grp_q <= grp_q;
                        f_stamp_q <= stamp_q;
                    end
                ST_DIVX:
                    if (div_done_q)
                    begin
                        state_q <= ST_DIVPU;
                        f_x_q <= quo_sat;
                        op_num_q <= 32'(f_prim_q) * 32'(CENTI);
                        op_den_q <= 18'(nom_current_i);
                        div_go_q <= 1'b1;
                    end
                ST_DIVPU:
                    if (div_done_q)
                    begin
                        state_q <= ST_DIVD;
                        f_pu_q <= quo_sat;
                        op_num_q <= 32'(f_x_q) * 32'(CENTI);
                        op_den_q <= 18'(line_a_q);
                        div_go_q <= 1'b1;
                    end
                ST_DIVD:
                    if (div_done_q)
                    begin
                        state_q <= ST_WRITE;
                        f_dist_q <= quo_sat;
                    end
                ST_WRITE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Restoring divider, one quotient bit per cycle
    // ----------------------------------------------------------------
    logic [17:0] div_rem_q;
    logic [5:0] div_cnt_q;
    logic [18:0] rem_sh;
    assign rem_sh = {div_rem_q, div_quo_q[31]};

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_rem_q <= '0;
            div_quo_q <= '0;
            div_cnt_q <= '0;
            div_done_q <= 1'b0;
        end
        else
        begin
            div_done_q <= 1'b0;
            if (div_go_q)
            begin
                div_rem_q <= '0;
                div_quo_q <= op_num_q;
                div_cnt_q <= DIV_STEPS;
            end
            else if (div_cnt_q != 6'h0)
            begin
                div_cnt_q <= div_cnt_q - 6'h1;
                div_done_q <= (div_cnt_q == 6'h1);
                if (op_den_q == 18'h0)
                begin
                    // Zero divisor forces a zero result
                    div_rem_q <= '0;
                    div_quo_q <= '0;
                end
                else if (rem_sh >= {1'b0, op_den_q})
                begin
                    div_rem_q <= 18'(rem_sh - {1'b0, op_den_q});
                    div_quo_q <= {div_quo_q[30:0], 1'b1};
                end
                else
                begin
                    div_rem_q <= rem_sh[17:0];
                    div_quo_q <= {div_quo_q[30:0], 1'b0};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    logic busy_q;
    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            calc_o <= 1'b0;
            evt_o <= '0;
            evt_stamp_o <= '0;
        end
        else
        begin
            busy_q <= busy;
            calc_o <= busy;
            evt_o[EV_TRIG_ON] <= accept && evt_on_en_i;
            evt_o[EV_TRIG_OFF] <= trig_fall && triggered_o && evt_off_en_i;
            evt_o[EV_CALC_ON] <= busy && !busy_q && evt_on_en_i;
            evt_o[EV_CALC_OFF] <= !busy && busy_q && evt_off_en_i;
            evt_stamp_o <= stamp_q;
        end
    end

    // ----------------------------------------------------------------
    // Operation log
    // ----------------------------------------------------------------
    // Separate arrays per field keep each read mux narrow
    logic [31:0] lg_stamp [12];
    logic [2:0] lg_type [12];
    logic [1:0] lg_dir [12];
    logic [15:0] lg_x [12];
    logic [15:0] lg_pu [12];
    logic [15:0] lg_prim [12];
    logic [15:0] lg_dist [12];
    logic [2:0] lg_grp [12];
    logic [3:0] wr_ptr_q;
    logic [3:0] rd_pos;
    logic wr_en;

    assign wr_en = (state_q == ST_WRITE);
    // Index 0 is the newest record
    assign rd_pos = (wr_ptr_q > log_rd_idx_i) ? wr_ptr_q - log_rd_idx_i - 4'h1 :
        4'(wr_ptr_q + LOG_DEPTH - log_rd_idx_i - 4'h1);

    always_ff @(posedge core_clk_i)
    begin
        if (wr_en)
        begin
            lg_stamp[wr_ptr_q] <= f_stamp_q;
            lg_type[wr_ptr_q] <= f_type_q;
            lg_dir[wr_ptr_q] <= f_dir_q;
            lg_x[wr_ptr_q] <= f_x_q;
            lg_pu[wr_ptr_q] <= f_pu_q;
            lg_prim[wr_ptr_q] <= f_prim_q;
            lg_dist[wr_ptr_q] <= f_dist_q;
            lg_grp[wr_ptr_q] <= f_grp_q;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            log_count_o <= '0;
        end
        else if (wr_en)
        begin
            wr_ptr_q <= (wr_ptr_q == LOG_DEPTH - 4'h1) ? 4'h0 : wr_ptr_q + 4'h1;
            if (log_count_o != LOG_DEPTH)
                log_count_o <= log_count_o + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            log_valid_o <= 1'b0;
            log_stamp_o <= '0;
            log_event_o <= '0;
            log_type_o <= '0;
            log_dir_o <= '0;
            log_x_o <= '0;
            log_pu_o <= '0;
            log_prim_o <= '0;
            log_dist_o <= '0;
            log_grp_o <= '0;
        end
        else
        begin
            log_valid_o <= (log_rd_idx_i < log_count_o);
            log_stamp_o <= lg_stamp[rd_pos];
            log_event_o <= 4'h1 << EV_CALC_ON;
            log_type_o <= lg_type[rd_pos];
            log_dir_o <= lg_dir[rd_pos];
            log_x_o <= lg_x[rd_pos];
            log_pu_o <= lg_pu[rd_pos];
            log_prim_o <= lg_prim[rd_pos];
            log_dist_o <= lg_dist[rd_pos];
            log_grp_o <= lg_grp[rd_pos];
        end
    end

endmodule

// ===== pkg/fdl_pkg.sv
// Constants, state and code types of the fault distance locator.
// Assumes a single 25 MHz core clock; no bus, all settings arrive as ports.
package fdl_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MS_NS = 1000000;
    // Cycles per timestamp millisecond (25000; the top takes it as its MS_CYC default)
    localparam int unsigned MS_CYC = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned TIME_BASE_MS = 5;

    // ----------------------------------------------------------------
    // Settings after reset
    // ----------------------------------------------------------------
    localparam logic [8:0] THR_RST = 9'h00a;       // 1.0 x nominal, 0.1 steps
    localparam logic [15:0] LINE_A_RST = 16'h007d; // 0.125 ohm/km, mohm/km units
    localparam logic [2:0] GROUP_RST = 3'h0;

    // ----------------------------------------------------------------
    // Scaling and sizes
    // ----------------------------------------------------------------
    localparam logic [9:0] MOHM_PER_OHM = 10'h3e8;  // 1000
    localparam logic [6:0] CENTI = 7'h64;           // 100
    localparam logic [3:0] THR_SCALE = 4'ha;        // threshold is in tenths
    localparam logic [5:0] DIV_STEPS = 6'h20;
    localparam logic [3:0] LOG_DEPTH = 4'hc;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        FT_L12 = 3'h0,
        FT_L23 = 3'h1,
        FT_L31 = 3'h2,
        FT_L1N = 3'h3,
        FT_L2N = 3'h4,
        FT_L3N = 3'h5,
        FT_L123 = 3'h6
    } fdl_ftype_t;

    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_FWD = 2'h1;
    localparam logic [1:0] DIR_REV = 2'h2;

    // Bit positions in the event pulse vector
    localparam int unsigned EV_TRIG_ON = 0;
    localparam int unsigned EV_TRIG_OFF = 1;
    localparam int unsigned EV_CALC_ON = 2;
    localparam int unsigned EV_CALC_OFF = 3;

    // Gray along idle -> reactance -> per-unit -> distance -> write
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_DIVX = 3'b001,
        ST_DIVPU = 3'b011,
        ST_DIVD = 3'b010,
        ST_WRITE = 3'b110
    } fdl_state_t;

endpackage

// ===== sim/fdl_fault_locator_assertions.sv
// Timing checks on the fault locator top-level ports.
// Assumes one clock domain and the active-low reset of the top.
`timescale 1ns/10ps
module fdl_fault_locator_assertions
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic cnt_clr_i,
    input wire logic triggered_o,
    input wire logic calc_o,
    input wire logic blocked_o,
    input wire logic [3:0] evt_o,
    input wire logic [15:0] trig_cnt_o,
    input wire logic [3:0] log_count_o
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_blocked_quiet: assert property ($rose(blocked_o) |-> !triggered_o && evt_o[0] == 1'b0)
        else $error("blocked trigger was accepted");
    chk_blk_excl: assert property (!(blocked_o && triggered_o))
        else $error("blocked and triggered together");
    chk_cnt_step: assert property ($rose(triggered_o) && !$past(cnt_clr_i)
        |-> trig_cnt_o == $past(trig_cnt_o) + 16'h1)
        else $error("counter did not step by one");
    chk_cnt_clear: assert property ($past(cnt_clr_i) && !$rose(triggered_o)
        |-> trig_cnt_o == 16'h0)
        else $error("counter not cleared");
    chk_trig_event: assert property (evt_o[0] |-> $rose(triggered_o))
        else $error("trigger event without trigger");
    chk_calc_event: assert property (evt_o[2] |-> $rose(calc_o))
        else $error("calc event without calc start");
    chk_calc_off: assert property (evt_o[3] |-> $fell(calc_o))
        else $error("calc off event misplaced");
    chk_calc_cause: assert property ($rose(calc_o) |-> $past(triggered_o))
        else $error("calc started without trigger");
    chk_calc_span: assert property ($rose(calc_o) |-> calc_o[*8] ##[1:400] !calc_o)
        else $error("calc length out of range");
    chk_log_depth: assert property (log_count_o <= 4'hc)
        else $error("log count above depth");
endmodule

bind fdl_fault_locator fdl_fault_locator_assertions chk_i (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .cnt_clr_i(cnt_clr_i), .triggered_o(triggered_o), .calc_o(calc_o),
    .blocked_o(blocked_o), .evt_o(evt_o), .trig_cnt_o(trig_cnt_o), .log_count_o(log_count_o));

// ===== sim/fdl_front_end.sv
// Measurement front end: program cycle ticks and refreshed phase currents.
// Assumes the bench supplies the wanted magnitudes as levels.
`timescale 1ns/10ps
module fdl_front_end #(
    parameter int TICK = 8
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] ia_i,
    input wire logic [15:0] ib_i,
    input wire logic [15:0] ic_i,
    output logic tick_o,
    output logic [15:0] ia_o,
    output logic [15:0] ib_o,
    output logic [15:0] ic_o
);
    int cnt;
    // ----------------------------------------------------------------
    // Magnitudes change only at the refresh, a scaled-down time base
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= 0;
            tick_o <= 1'b0;
            {ia_o, ib_o, ic_o} <= '0;
        end
        else
        begin
            cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
            tick_o <= (cnt == TICK - 1);
            if (cnt == TICK - 1)
            begin
                {ia_o, ib_o, ic_o} <= {ia_i, ib_i, ic_i};
            end
        end
    end
endmodule

// ===== sim/tb_fault_distance_locator.sv
// Self-checking bench for the fault locator.
// Assumes the front-end model supplies ticks and currents.
`timescale 1ns/10ps
module tb_fault_distance_locator;
    import fdl_pkg::*;
    logic clk = 0, rst_n = 0, tick, pe = 1, clr = 0, trg, calc, blk, lval, eon = 1, eoff = 1;
    logic [31:0] bin = '0;
    logic [7:0] bsrc = '0, bsel = '0;
    logic [15:0] ia = 0, ib = 0, ic = 0, pa, pb, pc, u1 = 0, u2 = 0, u3 = 0;
    logic [15:0] la = 16'h7d, cnt, lx, lpu, ldist;
    logic [8:0] thr = 9'h00a;
    logic [2:0] grp = 3'h2, ltyp, lgrp;
    logic [1:0] dir = DIR_FWD, ldir;
    logic [3:0] ev, lcnt, ridx = 0;
    int n_fail = 0, n_tests = 0, cyc = 0, nrec = 0, nev = 0;

    initial forever #20 clk = ~clk;

    fdl_front_end #(.TICK(8)) fe (.clk_i(clk), .rst_n_i(rst_n), .ia_i(ia), .ib_i(ib),
        .ic_i(ic), .tick_o(tick), .ia_o(pa), .ib_o(pb), .ic_o(pc));

    fdl_fault_locator #(.MS_CYC(10)) dut (.core_clk_i(clk), .rst_n_i(rst_n),
        .cycle_tick_i(tick), .bin_sig_i(bin), .trig_sel_i(5'h03), .blk_src_i(bsrc),
        .blk_sel_i(bsel), .pe_wired_i(pe), .phase_a_current_i(pa), .phase_b_current_i(pb),
        .phase_c_current_i(pc), .volt_1_i(u1), .volt_2_i(u2), .volt_3_i(u3),
        .volt_4_i(16'h0), .nom_current_i(16'h64), .trig_thr_i(thr), .line_a_i(la),
        .set_group_i(grp), .dir_i(dir), .evt_on_en_i(eon), .evt_off_en_i(eoff),
        .cnt_clr_i(clr), .log_rd_idx_i(ridx), .triggered_o(trg), .calc_o(calc),
        .blocked_o(blk), .evt_o(ev), .evt_stamp_o(), .trig_cnt_o(cnt), .log_count_o(lcnt),
        .log_valid_o(lval), .log_stamp_o(), .log_event_o(), .log_type_o(ltyp),
        .log_dir_o(ldir), .log_x_o(lx), .log_pu_o(lpu), .log_prim_o(), .log_dist_o(ldist),
        .log_grp_o(lgrp));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", s, e, g);
        end
    endtask

    // Raise the trigger, wait for the decision and any calculation
    task automatic fire(output logic saw_blk);
        int k;
        step(20);
        bin[3] = 1'b1;
        k = 0;
        while (trg !== 1'b1 && blk !== 1'b1 && k < 40)
        begin
            step(1);
            k++;
        end
        // Judged before the calculation wait, which keeps adding to k
        chk("decision", 1, k < 40);
        saw_blk = blk;
        step(2);
        while (calc === 1'b1 && k < 400)
        begin
            step(1);
            k++;
        end
        bin[3] = 1'b0;
        step(24);
    endtask

    task automatic rec(logic [2:0] t, logic [15:0] x, logic [15:0] d);
        nrec = (nrec < 12) ? nrec + 1 : 12;
        chk("count", nrec, lcnt);
        chk("valid", 1, lval);
        chk("type", t, ltyp);
        chk("react", x, lx);
        chk("dist", d, ldist);
        chk("group", grp, lgrp);
        chk("dir", dir, ldir);
    endtask

    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_loops();
        logic b;
        {ia, ib, ic, u1, u2} = {16'd200, 16'd200, 16'd200, 16'd1000, 16'd1000};
        fire(b);
        chk("trig count", 1, cnt);
        rec(FT_L123, 16'd5000, 16'd4000);
        {ia, ib, ic, u2, u3, la, dir, grp} = {16'd0, 16'd150, 16'd150, 16'd600, 16'd600, 16'd0,
            DIR_REV, 3'h5};
        fire(b);
        rec(FT_L23, 16'd4000, 16'd0);
        {ib, la} = {16'd0, 16'd500};
        ic = 16'd300;
        fire(b);
        rec(FT_L3N, 16'd2000, 16'd400);
        chk("pu", 16'd300, lpu);
        ridx = 4'h1;
        step(2);
        chk("older type", FT_L23, ltyp);
        ridx = 4'h0;
        step(2);
        $display("test loops done");
    endtask

    task automatic t_refused();
        logic b;
        {pe, eon, eoff} = 3'b000;
        fire(b);
        chk("no pe rec", nrec, lcnt);
        {pe, eon, eoff} = 3'b111;
        thr = 9'h028;
        fire(b);
        chk("low cur rec", nrec, lcnt);
        thr = 9'h00a;
        {bsrc, bsel} = {8'h01, 8'h01};
        fire(b);
        chk("blocked", 1, b);
        chk("blk count", 5, cnt);
        chk("blk rec", nrec, lcnt);
        bsel = 8'h02;
        fire(b);
        rec(FT_L3N, 16'd2000, 16'd400);
        chk("masked events", 10, nev);
        $display("test refused done");
    endtask

    task automatic t_wrap();
        logic b;
        repeat (12)
        begin
            fire(b);
            rec(FT_L3N, 16'd2000, 16'd400);
        end
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(1);
        chk("cleared", 0, cnt);
        $display("test wrap done");
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // Trigger ON and OFF pulses seen so far
    always @(posedge clk)
        nev += int'(ev[0] === 1'b1) + int'(ev[1] === 1'b1);

    initial
    begin
        step(16);
        rst_n = 1'b1;
        step(4);
        t_loops();
        t_refused();
        t_wrap();
        end_of_test();
    end
endmodule
